// file: inc/cbcba_pkg.sv
// Operation
// [RULE_01] start strobe one clock, in-progress held
// [RULE_02] cycle ends on ack or error ack
// [RULE_03] emulator refuses ack before one wait
// [RULE_04] target acks only after wait state
// [RULE_05] target inserts at least one wait
// [RULE_06] burst carries four data transfers
// [RULE_07] burst: address and start strobe once
// [RULE_08] burst requested through transfer size code
// [RULE_09] burst inhibit falls back to single transfer
// [RULE_10] burst ends on fourth acknowledge
// [RULE_11] target waits between burst transfers
// [RULE_12] memory advances line address bits
// [RULE_13] request bus, arbiter answers with grant
// [RULE_14] take bus only when busy released
// [RULE_15] no request while reset asserted
// [RULE_16] alternate master start needs matching ack
// [RULE_17] no alternate capture during reset
// [RULE_18] reset fetches stack then program counter
// [RULE_19] fault during exception gives double fault
// [RULE_20] odd handler vector raises address error
// [RULE_21] bus error in stacking or fetch: double
// [RULE_22] bus error from error ack or mmu
package cbcba_pkg;
  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 32;
  localparam logic [1:0]  SIZE_LONG   = 2'h0;
  localparam logic [1:0]  SIZE_BYTE   = 2'h1;
  localparam logic [1:0]  SIZE_WORD   = 2'h2;
  localparam logic [1:0]  SIZE_LINE   = 2'h3;
  localparam logic [2:0]  BURST_BEATS = 3'h4;
  localparam logic [31:0] RESET_SP_ADDR = 32'h0000_0000;
  localparam logic [31:0] RESET_PC_ADDR = 32'h0000_0004;
  localparam logic [31:0] ADDR_ERR_VEC  = 32'h0000_000c;
  localparam int          WAIT_MIN    = 1;
  localparam int          MEM_WAIT    = 1;
endpackage

// file: inc/cbcba_if.sv
`timescale 1ns/100ps
interface cbcba_if;
  import cbcba_pkg::*;
  // open-drain style strobes resolved from enables; low-true on the wire
  logic              ts_out;
  logic              ts_oe;
  logic              transfer_in_progress_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              write;
  logic [1:0]        transfer_size;
  logic              transfer_ack_n;
  logic              transfer_error_ack_n;
  logic              burst_inhibit_n;
  logic              bus_request_n;
  logic              bus_grant_n;
  logic              bb_out;
  logic              bb_oe;
  logic              am_ts_out;
  logic              am_ts_oe;
  logic              am_bb_out;
  logic              am_bb_oe;
  logic              transfer_start_n;
  logic              bus_busy_n;
  assign transfer_start_n = (ts_oe ? ts_out : 1'b1) &
                            (am_ts_oe ? am_ts_out : 1'b1);
  assign bus_busy_n = (bb_oe ? bb_out : 1'b1) & (am_bb_oe ? am_bb_out : 1'b1);
  modport cpu (
    output ts_out, ts_oe, transfer_in_progress_n, addr, wdata, write,
    output transfer_size, bus_request_n, bb_out, bb_oe,
    input  rdata, transfer_ack_n, transfer_error_ack_n, burst_inhibit_n,
    input  bus_grant_n, transfer_start_n, bus_busy_n
  );
  modport tgt (
    input  transfer_start_n, transfer_in_progress_n, addr, wdata, write,
    input  transfer_size, bus_request_n, bus_busy_n,
    output rdata, transfer_ack_n, transfer_error_ack_n, burst_inhibit_n,
    output bus_grant_n, am_ts_out, am_ts_oe, am_bb_out, am_bb_oe
  );
endinterface

// file: core/cbcba_cpu.sv
`timescale 1ns/100ps
module cbcba_cpu #(
  parameter bit WAIT_EN = 1'b1
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  cbcba_if.cpu                            bus,
  input  wire logic                       req_valid,
  input  wire logic                       req_write,
  input  wire logic                       req_line,
  input  wire logic                       req_exc,
  input  wire logic [1:0]                 req_size,
  input  wire logic [cbcba_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [cbcba_pkg::DATA_W-1:0] req_wdata,
  input  wire logic                       mmu_fault,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic [cbcba_pkg::DATA_W-1:0]    rsp_data,
  output logic                            rsp_error,
  output logic                            rsp_last,
  output logic [cbcba_pkg::DATA_W-1:0]    init_sp,
  output logic [cbcba_pkg::DATA_W-1:0]    init_pc,
  output logic                            boot_done,
  output logic                            addr_error,
  output logic                            double_fault,
  output logic                            am_capture
);
  import cbcba_pkg::*;
  typedef enum {
    CPU_BOOT_SP, CPU_BOOT_PC, CPU_IDLE, CPU_ARB, CPU_BUSY_WAIT,
    CPU_START, CPU_DATA, CPU_VEC, CPU_AERR, CPU_HALT
  } cbcba_state_t;
  typedef struct packed {
    cbcba_state_t        st;
    logic                ts_out;
    logic                ts_oe;
    logic                tip_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                write;
    logic [1:0]          size;
    logic                br_n;
    logic                bb_out;
    logic                bb_oe;
    logic                owner;
    logic                burst;
    logic [2:0]          beats;
    logic                waited;
    logic                in_exc;
    logic                rsp_valid;
    logic [DATA_W-1:0]   rsp_data;
    logic                rsp_error;
    logic                rsp_last;
    logic [DATA_W-1:0]   init_sp;
    logic [DATA_W-1:0]   init_pc;
    logic                boot_done;
    logic                addr_error;
    logic                double_fault;
    logic                am_capture;
    logic                am_cycle;
    logic                req_ready;
  } cbcba_cpu_t;
  cbcba_cpu_t s_reg;
  cbcba_cpu_t s_next;
  logic ack_ok;
  logic err;
  logic done;
  function automatic cbcba_cpu_t start_cycle(input cbcba_cpu_t s,
      input logic [ADDR_W-1:0] a, input logic [1:0] sz, input logic w);
    cbcba_cpu_t r;
    r        = s;
    r.st     = CPU_START;
    r.addr   = a;
    r.size   = sz;
    r.write  = w;
    r.ts_out = 1'b0;
    r.ts_oe  = 1'b1;
    r.tip_n  = 1'b0;
    r.beats  = 3'h0;
    r.waited = 1'b0;
    r.burst  = (sz == SIZE_LINE);
    return r;
  endfunction
  always_comb begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.rsp_last  = 1'b0;
    s_next.rsp_error = 1'b0;
    s_next.ts_out    = 1'b1;
    // [RULE_03] refuse early ack
    ack_ok = !WAIT_EN || s_reg.waited;
    // [RULE_22] error from target or mmu
    err  = !bus.transfer_error_ack_n || mmu_fault;
    // [RULE_02] ack or error ends cycle
    done = ack_ok && (!bus.transfer_ack_n || err);
    // [RULE_17] alternate cycles seen only out of reset
    if (!s_reg.owner && !bus.transfer_start_n) begin
      s_next.am_cycle = 1'b1;
    end else if (!s_reg.owner && !bus.transfer_ack_n) begin
      s_next.am_cycle = 1'b0;
    end
    s_next.am_capture = !s_reg.owner && !bus.transfer_start_n;
    case (s_reg.st)
      CPU_BOOT_SP, CPU_BOOT_PC: begin
        // [RULE_15] request only after reset release
        if (s_reg.owner) begin
          // [RULE_18] stack pointer then pc
          s_next = start_cycle(s_next, s_reg.st == CPU_BOOT_SP ?
                     RESET_SP_ADDR : RESET_PC_ADDR, SIZE_LONG, 1'b0);
          s_next.st = s_reg.st == CPU_BOOT_SP ? CPU_DATA : CPU_VEC;
          s_next.in_exc = 1'b1;
        end else begin
          s_next.br_n = 1'b0;
          s_next.st = CPU_ARB;
        end
      end
      CPU_IDLE: begin
        s_next.ts_oe = 1'b0;
        if (req_valid) begin
          s_next.req_ready = 1'b0;
          s_next.wdata     = req_wdata;
          s_next.in_exc    = req_exc;
          s_next.burst     = req_line;
          s_next.addr      = req_addr;
          // [RULE_08] line code requests burst
          s_next.size      = req_line ? SIZE_LINE : req_size;
          s_next.write     = req_write;
          // [RULE_13] ask for bus
          s_next.br_n = 1'b0;
          s_next.st   = CPU_ARB;
        end
      end
      CPU_ARB: begin
        if (!bus.bus_grant_n && !s_reg.am_cycle) begin
          s_next.st = CPU_BUSY_WAIT;
        end
      end
      CPU_BUSY_WAIT: begin
        // [RULE_14] wait for idle bus
        if (!bus.bus_grant_n && bus.bus_busy_n) begin
          s_next.br_n   = 1'b1;
          s_next.owner  = 1'b1;
          s_next.bb_out = 1'b0;
          s_next.bb_oe  = 1'b1;
          if (!s_reg.boot_done) begin
            s_next.st = s_reg.init_sp == '0 && s_reg.rsp_data == '0 &&
                        !s_reg.addr_error ? CPU_BOOT_SP : CPU_BOOT_PC;
          end else begin
            // [RULE_07] address and strobe once
            s_next = start_cycle(s_next, s_reg.addr, s_reg.size,
                                 s_reg.write);
          end
        end else if (bus.bus_grant_n) begin
          s_next.st = CPU_ARB;
        end
      end
      CPU_START, CPU_DATA, CPU_VEC: begin
        // [RULE_01] strobe one clock, tip held
        s_next.waited = 1'b1;
        if (done) begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = bus.rdata;
          s_next.rsp_error = err;
          s_next.beats     = s_reg.beats + 3'h1;
          // [RULE_09] inhibit forces single
          if (!bus.burst_inhibit_n) begin
            s_next.burst = 1'b0;
          end
          s_next.waited = 1'b0;
          // [RULE_06] four beats per line
          // [RULE_10] wait for fourth ack
          if (err || !s_reg.burst || !bus.burst_inhibit_n ||
              s_reg.beats == BURST_BEATS - 3'h1) begin
            s_next.rsp_last = 1'b1;
            s_next.tip_n    = 1'b1;
            s_next.st       = CPU_IDLE;
            s_next.req_ready = 1'b1;
            if (!s_reg.boot_done) begin
              if (s_reg.addr == RESET_SP_ADDR) begin
                s_next.init_sp = bus.rdata;
                s_next.st = CPU_BOOT_PC;
              end else begin
                s_next.init_pc = bus.rdata;
                s_next.boot_done = 1'b1;
                s_next.in_exc = 1'b0;
                // [RULE_18] odd pc is fatal
                if (bus.rdata[0]) begin
                  s_next.double_fault = 1'b1;
                  s_next.st = CPU_HALT;
                end
              end
              // [RULE_21] error during vector fetch
              if (err) begin
                s_next.double_fault = 1'b1;
                s_next.st = CPU_HALT;
              end
            end else if (s_reg.in_exc && err) begin
              // [RULE_21] error while stacking
              s_next.double_fault = 1'b1;
              s_next.st = CPU_HALT;
            end else if (s_reg.in_exc && !s_reg.write &&
                         bus.rdata[0]) begin
              // [RULE_20] odd handler vector
              // [RULE_19] second fault in exception
              if (s_reg.addr_error) begin
                s_next.double_fault = 1'b1;
                s_next.st = CPU_HALT;
              end else begin
                s_next.addr_error = 1'b1;
                // tip released one clock before the vector fetch
                s_next.st = CPU_AERR;
              end
            end
          end
        end
      end
      CPU_AERR: begin
        s_next = start_cycle(s_next, ADDR_ERR_VEC, SIZE_LONG, 1'b0);
      end
      CPU_HALT: begin
        s_next.ts_oe = 1'b0;
        s_next.req_ready = 1'b0;
      end
      default: s_next.st = CPU_HALT;
    endcase
    // drop ownership once idle or halted
    if (s_next.st == CPU_IDLE || s_next.st == CPU_HALT) begin
      s_next.owner = 1'b0;
      s_next.bb_oe = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= '{st: CPU_BOOT_SP, ts_out: 1'b1, tip_n: 1'b1, br_n: 1'b1,
                 bb_out: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign bus.ts_out                 = s_reg.ts_out;
  assign bus.ts_oe                  = s_reg.ts_oe;
  assign bus.transfer_in_progress_n = s_reg.tip_n;
  assign bus.addr                   = s_reg.addr;
  assign bus.wdata                  = s_reg.wdata;
  assign bus.write                  = s_reg.write;
  assign bus.transfer_size          = s_reg.size;
  assign bus.bus_request_n          = s_reg.br_n;
  assign bus.bb_out                 = s_reg.bb_out;
  assign bus.bb_oe                  = s_reg.bb_oe;
  assign req_ready    = s_reg.req_ready;
  assign rsp_valid    = s_reg.rsp_valid;
  assign rsp_data     = s_reg.rsp_data;
  assign rsp_error    = s_reg.rsp_error;
  assign rsp_last     = s_reg.rsp_last;
  assign init_sp      = s_reg.init_sp;
  assign init_pc      = s_reg.init_pc;
  assign boot_done    = s_reg.boot_done;
  assign addr_error   = s_reg.addr_error;
  assign double_fault = s_reg.double_fault;
  assign am_capture   = s_reg.am_capture;
endmodule

// file: core/cbcba_tgt.sv
`timescale 1ns/100ps
module cbcba_tgt #(
  parameter int WAIT_STATES = cbcba_pkg::MEM_WAIT
) (
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  cbcba_if.tgt                              bus,
  input  wire logic                         inhibit_burst,
  input  wire logic                         fail_access,
  input  wire logic                         am_request,
  input  wire logic [cbcba_pkg::DATA_W-1:0] mem_rdata,
  output logic [3:2]                        mem_line_addr,
  output logic                              mem_write,
  output logic                              mem_strobe,
  output logic                              am_granted
);
  import cbcba_pkg::*;
  if (WAIT_STATES < 1 || WAIT_STATES > 7) begin : g_bad_wait
    $error("wait states out of range");
  end
  typedef enum {T_IDLE, T_WAIT, T_ACK, T_AM} cbcba_tstate_t;
  typedef struct packed {
    cbcba_tstate_t  st;
    logic [2:0]     wcnt;
    logic [2:0]     beat;
    logic           burst;
    logic [1:0]     line;
    logic           ta_n;
    logic           tea_n;
    logic           tbi_n;
    logic           bg_n;
    logic [DATA_W-1:0] rdata;
    logic           am_ts;
    logic           am_bb;
    logic           strobe;
  } cbcba_tgt_t;
  cbcba_tgt_t s_reg;
  cbcba_tgt_t s_next;
  always_comb begin
    s_next        = s_reg;
    s_next.ta_n   = 1'b1;
    s_next.tea_n  = 1'b1;
    s_next.tbi_n  = 1'b1;
    s_next.am_ts  = 1'b0;
    s_next.strobe = 1'b0;
    // [RULE_13] grant requester
    s_next.bg_n = bus.bus_request_n || s_reg.st == T_AM;
    case (s_reg.st)
      T_IDLE: begin
        if (!bus.transfer_start_n && !s_reg.am_bb) begin
          s_next.st    = T_WAIT;
          s_next.wcnt  = 3'h0;
          s_next.beat  = 3'h0;
          s_next.line  = bus.addr[3:2];
          s_next.burst = bus.transfer_size == SIZE_LINE && !inhibit_burst;
        end else if (am_request && bus.bus_request_n &&
                     bus.bus_busy_n) begin
          s_next.st    = T_AM;
          s_next.am_bb = 1'b1;
          s_next.wcnt  = 3'h0;
          s_next.am_ts = 1'b1;
        end
      end
      T_WAIT: begin
        // [RULE_05] at least one wait
        // [RULE_11] wait between beats
        s_next.wcnt = s_reg.wcnt + 3'h1;
        if (s_reg.wcnt == 3'(WAIT_STATES - 1)) begin
          // [RULE_04] ack after wait state
          s_next.st     = T_ACK;
          s_next.strobe = 1'b1;
          s_next.ta_n   = fail_access;
          s_next.tea_n  = !fail_access;
          s_next.rdata  = mem_rdata;
          // [RULE_09] refuse burst
          s_next.tbi_n  = s_reg.burst || bus.transfer_size != SIZE_LINE;
        end
      end
      T_ACK: begin
        s_next.beat = s_reg.beat + 3'h1;
        // [RULE_12] advance line bits
        s_next.line = s_reg.line + 2'h1;
        s_next.wcnt = 3'h0;
        if (s_reg.burst && s_reg.tea_n &&
            s_reg.beat != BURST_BEATS - 3'h1) begin
          s_next.st = T_WAIT;
        end else begin
          s_next.st = T_IDLE;
        end
      end
      T_AM: begin
        // [RULE_16] alternate start paired with ack
        // [RULE_05] one wait before this ack too
        s_next.wcnt = 3'h1;
        if (s_reg.wcnt != 3'h0) begin
          s_next.ta_n  = 1'b0;
          s_next.am_bb = 1'b0;
          s_next.st    = T_IDLE;
        end
      end
      default: s_next.st = T_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg <= '{st: T_IDLE, ta_n: 1'b1, tea_n: 1'b1, tbi_n: 1'b1,
                 bg_n: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign bus.transfer_ack_n       = s_reg.ta_n;
  assign bus.transfer_error_ack_n = s_reg.tea_n;
  assign bus.burst_inhibit_n      = s_reg.tbi_n;
  assign bus.bus_grant_n          = s_reg.bg_n;
  assign bus.rdata                = s_reg.rdata;
  assign bus.am_ts_out            = 1'b0;
  assign bus.am_ts_oe             = s_reg.am_ts;
  assign bus.am_bb_out            = 1'b0;
  assign bus.am_bb_oe             = s_reg.am_bb;
  assign mem_line_addr = s_reg.line;
  assign mem_write     = bus.write;
  assign mem_strobe    = s_reg.strobe;
  assign am_granted    = s_reg.am_bb;
endmodule

// file: verification/cbcba_asserts.sv
`timescale 1ns/100ps
module cbcba_asserts
  import cbcba_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       transfer_start_n,
  input wire logic       ts_oe,
  input wire logic       transfer_in_progress_n,
  input wire logic       transfer_ack_n,
  input wire logic       transfer_error_ack_n,
  input wire logic       burst_inhibit_n,
  input wire logic [1:0] transfer_size,
  input wire logic       bus_request_n,
  input wire logic       bus_grant_n,
  input wire logic       bus_busy_n,
  input wire logic       bb_oe
);
  logic [2:0] beat_reg;
  logic       line_reg;
  logic       inh_reg;
  logic       err_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // cleared by any start, alternate master too
  always_ff @(posedge clk_sys) begin
    if (reset || !transfer_start_n) begin
      beat_reg <= 3'h0;
      inh_reg  <= 1'b0;
      err_reg  <= 1'b0;
      line_reg <= transfer_size == SIZE_LINE;
    end else begin
      if (!transfer_ack_n && !transfer_in_progress_n) begin
        beat_reg <= beat_reg + 3'h1;
      end
      if (!burst_inhibit_n) begin
        inh_reg <= 1'b1;
      end
      if (!transfer_error_ack_n) begin
        err_reg <= 1'b1;
      end
    end
  end

  chk_start_pulse: assert property (
    !transfer_start_n |=> transfer_start_n) else $error("start too long");
  chk_tip_start: assert property (
    !transfer_start_n && ts_oe |-> !transfer_in_progress_n)
    else $error("tip not low at start");
  chk_ack_refused: assert property (
    !transfer_start_n |=> transfer_ack_n && transfer_error_ack_n)
    else $error("ack without wait state");
  chk_start_answered: assert property (
    !transfer_start_n |-> ##[2:40] (!transfer_ack_n || !transfer_error_ack_n))
    else $error("start never acknowledged");
  chk_error_ends: assert property (
    !transfer_error_ack_n && !transfer_in_progress_n
    |=> transfer_in_progress_n) else $error("error did not end cycle");
  chk_burst_four: assert property (
    $rose(transfer_in_progress_n) && line_reg && !inh_reg && !err_reg
    |-> beat_reg == 3'h4) else $error("burst beat count");
  chk_inhibit_single: assert property (
    $rose(transfer_in_progress_n) && line_reg && inh_reg && !err_reg
    |-> beat_reg == 3'h1) else $error("inhibited burst beat count");
  chk_one_start: assert property (
    !transfer_in_progress_n && !$past(transfer_in_progress_n)
    |-> !(!transfer_start_n && ts_oe)) else $error("second start in cycle");
  chk_req_reset: assert property (
    $fell(reset) |-> bus_request_n) else $error("request in reset");
  chk_grant_given: assert property (
    !bus_request_n |-> ##[0:40] !bus_grant_n) else $error("no grant");
  chk_take_idle: assert property (
    $rose(bb_oe) |-> $past(bus_busy_n) && !$past(bus_grant_n))
    else $error("bus taken while busy");

  cp_burst: cover property ($rose(transfer_in_progress_n) && beat_reg == 3'h4);
  cp_error: cover property (!transfer_error_ack_n);
  cp_am_start: cover property (!transfer_start_n && !ts_oe);
endmodule

// file: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import cbcba_pkg::*;
  logic              clk_sys, reset, req_valid, req_write, req_line, req_exc;
  logic [1:0]        req_size;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, mem_rdata, rsp_data, init_sp, init_pc;
  logic              mmu_fault, req_ready, rsp_valid, rsp_error, rsp_last;
  logic              boot_done, addr_error, double_fault, am_capture;
  logic              inhibit_burst, fail_access, am_request, pc_odd;
  logic [3:2]        mem_line_addr;
  logic              mem_write, mem_strobe, am_granted;
  int                error_cnt;
  int                comparisons;

  cbcba_if bif ();
  cbcba_cpu u_cbcba_cpu (
    .clk_sys(clk_sys), .reset(reset), .bus(bif), .req_valid(req_valid),
    .req_write(req_write), .req_line(req_line), .req_exc(req_exc),
    .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
    .mmu_fault(mmu_fault), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error), .rsp_last(rsp_last),
    .init_sp(init_sp), .init_pc(init_pc), .boot_done(boot_done),
    .addr_error(addr_error), .double_fault(double_fault),
    .am_capture(am_capture));
  cbcba_tgt u_cbcba_tgt (
    .clk_sys(clk_sys), .reset(reset), .bus(bif),
    .inhibit_burst(inhibit_burst), .fail_access(fail_access),
    .am_request(am_request), .mem_rdata(mem_rdata),
    .mem_line_addr(mem_line_addr), .mem_write(mem_write),
    .mem_strobe(mem_strobe), .am_granted(am_granted));
  cbcba_asserts u_cbcba_asserts (
    .clk_sys(clk_sys), .reset(reset),
    .transfer_start_n(bif.transfer_start_n), .ts_oe(bif.ts_oe),
    .transfer_in_progress_n(bif.transfer_in_progress_n),
    .transfer_ack_n(bif.transfer_ack_n),
    .transfer_error_ack_n(bif.transfer_error_ack_n),
    .burst_inhibit_n(bif.burst_inhibit_n),
    .transfer_size(bif.transfer_size), .bus_request_n(bif.bus_request_n),
    .bus_grant_n(bif.bus_grant_n), .bus_busy_n(bif.bus_busy_n),
    .bb_oe(bif.bb_oe));

  // data echoes its line bits so beat order shows
  assign mem_rdata = ({bif.addr[31:4], mem_line_addr, 2'h0} ^ 32'h5a00_0000)
                     | {31'h0, pc_odd};

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    error_cnt++;
    $display("BAD %s expected done seen timeout", what);
    summarize();
  endtask

  task automatic boot(input logic odd);
    int i;
    pc_odd = odd;
    reset = 1'b1;
    repeat (6) tick();
    reset = 1'b0;
    for (i = 0; i < 300; i++) begin
      if (boot_done === 1'b1 || double_fault === 1'b1) break;
      tick();
    end
    if (i == 300) hang("boot");
    chk("double_fault", {31'h0, odd}, {31'h0, double_fault});
    chk("init_sp", 32'h5a00_0000 | odd, init_sp);
    chk("init_pc", 32'h5a00_0004 | odd, init_pc);
  endtask

  task automatic xfer(input logic w, input logic ln, input logic ex,
                      input logic [1:0] sz, input logic [31:0] a,
                      output int n, output logic err);
    int i;
    logic [1:0] lb;
    n = 0;
    err = 1'b0;
    lb = a[3:2];
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) tick();
    if (i == 100) hang("req_ready");
    req_valid = 1'b1;
    req_write = w;
    req_line = ln;
    req_exc = ex;
    req_size = sz;
    req_addr = a;
    req_wdata = ~a;
    tick();
    req_valid = 1'b0;
    for (i = 0; i < 100; i++) begin
      tick();
      if (rsp_error === 1'b1) err = 1'b1;
      if (rsp_valid === 1'b1 && !err) begin
        n++;
        if (!w) chk("rsp_data", ({a[31:4], lb, 2'h0} ^ 32'h5a00_0000) |
                    {31'h0, pc_odd}, rsp_data);
        lb = lb + 2'h1;
      end
      if (rsp_last === 1'b1 || err) break;
    end
    if (i == 100) hang("response");
    chk("mem_write", {31'h0, w}, {31'h0, mem_write});
  endtask

  // long, byte and word size codes, reads and writes
  task automatic t_single();
    int n;
    logic e;
    for (int k = 0; k < 6; k++) begin
      xfer(k[0], 1'b0, 1'b0, k[2:1], 32'h0000_1004, n, e);
      chk("single beats", 1, n);
    end
  endtask

  // start at line slot 2 so the wrap is seen
  task automatic t_burst();
    int n;
    logic e;
    for (int w = 0; w < 2; w++) begin
      xfer(w[0], 1'b1, 1'b0, SIZE_LINE, 32'h0000_2008, n, e);
      chk("burst beats", 4, n);
    end
    inhibit_burst = 1'b1;
    xfer(1'b0, 1'b1, 1'b0, SIZE_LINE, 32'h0000_300c, n, e);
    chk("inhibited beats", 1, n);
    inhibit_burst = 1'b0;
  endtask

  task automatic t_error();
    int n;
    logic e;
    fail_access = 1'b1;
    xfer(1'b0, 1'b1, 1'b0, SIZE_LINE, 32'h0000_4000, n, e);
    chk("error ack", 1, e);
    fail_access = 1'b0;
    mmu_fault = 1'b1;
    xfer(1'b0, 1'b0, 1'b0, SIZE_LONG, 32'h0000_4010, n, e);
    chk("mmu error", 1, e);
    mmu_fault = 1'b0;
    xfer(1'b1, 1'b0, 1'b1, SIZE_LONG, 32'h0000_00fc, n, e);
    chk("clean stacking", 0, double_fault);
    fail_access = 1'b1;
    xfer(1'b1, 1'b0, 1'b1, SIZE_LONG, 32'h0000_00f8, n, e);
    chk("stacking fault", 1, double_fault);
    fail_access = 1'b0;
  endtask

  // odd handler vector, then odd address error vector
  task automatic t_vec();
    int i;
    int n;
    logic e;
    boot(1'b0);
    pc_odd = 1'b1;
    xfer(1'b0, 1'b0, 1'b1, SIZE_LONG, 32'h0000_0010, n, e);
    for (i = 0; i < 100 && double_fault !== 1'b1; i++) tick();
    if (i == 100) hang("vector double fault");
    chk("addr_error", 1, addr_error);
    chk("vector double", 1, double_fault);
    pc_odd = 1'b0;
  endtask

  // reset held with the alternate master asking
  task automatic t_am();
    int i;
    int caps;
    logic grt;
    caps = 0;
    grt = 1'b0;
    am_request = 1'b1;
    reset = 1'b1;
    for (i = 0; i < 6; i++) begin
      tick();
      if (am_capture === 1'b1) caps++;
    end
    chk("capture in reset", 0, caps);
    reset = 1'b0;
    for (i = 0; i < 100 && caps == 0; i++) begin
      tick();
      if (am_granted === 1'b1) grt = 1'b1;
      if (am_capture === 1'b1) caps++;
    end
    am_request = 1'b0;
    chk("capture running", 1, caps);
    chk("am granted", 1, grt);
    for (i = 0; i < 300 && boot_done !== 1'b1; i++) tick();
    chk("boot after am", 1, boot_done);
  endtask

  initial begin
    error_cnt = 0;
    comparisons = 0;
    reset = 1'b1;
    pc_odd = 1'b0;
    {req_valid, req_write, req_line, req_exc, mmu_fault} = 5'h0;
    {inhibit_burst, fail_access, am_request} = 3'h0;
    req_size = 2'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    boot(1'b0);
    t_single();
    t_burst();
    t_am();
    t_error();
    t_vec();
    boot(1'b1);
    summarize();
  end
endmodule
